// ==== verilog/gmlut_pkg.sv ====
package gmlut_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  // Offsets are register indices; the byte address is the index times four.
  localparam logic [11:0] GMLUT_IDX_CONTROL = 12'h83e;
  localparam logic [11:0] GMLUT_IDX_ADDRESS = 12'h840;
  localparam logic [11:0] GMLUT_IDX_DATA    = 12'h842;
  localparam logic [11:0] GMLUT_IDX_PSEUDO  = 12'h844;
  localparam int          GMLUT_BUS_AW      = 14;

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int GMLUT_CTL_ENABLE   = 0;
  localparam int GMLUT_CTL_AUTOINC  = 1;
  localparam int GMLUT_CTL_CLIP_DIS = 2;
  localparam int GMLUT_CTL_EXPAND   = 3;
  localparam int GMLUT_CTL_BANK_LO  = 4;
  localparam int GMLUT_CTL_WCOL_LO  = 8;
  localparam int GMLUT_CTL_OVL_LO   = 10;
  localparam int GMLUT_CTL_BYP_OV1  = 12;
  localparam int GMLUT_CTL_BYP_OV2  = 13;
  localparam int GMLUT_CTL_BYP_MAIN = 14;
  localparam logic [15:0] GMLUT_CTL_MASK  = 16'h7f3f;
  localparam logic [15:0] GMLUT_CTL_RESET = 16'h0000;
  localparam logic [15:0] GMLUT_PSC_MASK  = 16'h0007;
  localparam logic [15:0] GMLUT_PSC_RESET = 16'h0000;
  localparam logic [7:0]  GMLUT_ADDR_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] GMLUT_BANK_A_SHOW  = 2'h0;
  localparam logic [1:0] GMLUT_BANK_B_SHOW  = 2'h1;
  localparam logic [1:0] GMLUT_BANK_SPLIT   = 2'h2;
  localparam logic [1:0] GMLUT_BANK_BOTH_WR = 2'h3;
  localparam logic [1:0] GMLUT_OVL_BOTH = 2'h0;
  localparam logic [1:0] GMLUT_OVL_ONE  = 2'h1;
  localparam logic [1:0] GMLUT_OVL_TWO  = 2'h2;
  localparam logic [1:0] GMLUT_WCOL_R   = 2'h0;
  localparam logic [1:0] GMLUT_WCOL_G   = 2'h1;
  localparam logic [1:0] GMLUT_WCOL_B   = 2'h2;
  localparam logic [1:0] GMLUT_WCOL_ALL = 2'h3;
  localparam logic [2:0] GMLUT_PSC_TRUNC  = 3'h0;
  localparam logic [2:0] GMLUT_PSC_DITHER = 3'h1;
  localparam logic [2:0] GMLUT_PSC_FRM    = 3'h2;
  localparam logic [2:0] GMLUT_PSC_ERRDIF = 3'h4;

  // ---------------------------------------------------------------------------
  // Pixel carriers
  // ---------------------------------------------------------------------------
  localparam logic [1:0] GMLUT_WIN_MAIN = 2'h0;
  localparam logic [1:0] GMLUT_WIN_OV1  = 2'h1;
  localparam logic [1:0] GMLUT_WIN_OV2  = 2'h2;

  // Colour components are 8 bits with a per-component mask of bits that
  // came from colour conversion rather than from the frame buffer.
  typedef struct packed {
    logic       valid;
    logic [1:0] window;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] red_xmask;
    logic [7:0] green_xmask;
    logic [7:0] blue_xmask;
  } gmlut_pix_in_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } gmlut_pix_out_t;

  localparam int GMLUT_PANEL_W = 6;

endpackage

// ==== verilog/gmlut_top.sv ====
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
// Contract
// - Overlay selection field matters only when bank select is split mode.
// - Split mode overlay select: both overlays, first only, second only; 11 reserved.
// - Data write updates only the chosen colour component at the access address.
// - Colour select all writes the value into red, green and blue.
// - Bank select 00: A corrects main and first overlay; only B host-accessible.
// - Bank select 01: B corrects main and first overlay; only A host-accessible.
// - Bank select 10: A corrects main, B selected overlays; no host access.
// - Bank select 11: both banks written per data write; no correction.
// - A bank never serves display while the host programs it.
// - Expansion enable: extra bits zero, or copies of component MSB.
// - Clip disable low clips converted extra bits; high passes all bits.
// - Auto increment advances address after each data write that a bank accepts, else holds.
// - Table enable low: no correction and no host table access.
// - Write-only 8-bit access address register selects table index.
// - Data port write stores 8-bit value at current access address.
// - Pseudo colour: truncate, 2x2 dither, frame-rate modulation, error diffusion.
// - Each window has a bypass bit skipping the table.
module gmlut_top
  import gmlut_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic [GMLUT_BUS_AW-1:0] avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  output logic      [1:0]              avs_response,
  input  wire gmlut_pix_in_t           pix_in,
  input  wire logic                    frame_start,
  output gmlut_pix_out_t               pix_out
);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  logic [15:0] ctl_q;
  logic [15:0] psc_q;
  logic [7:0]  addr_q;
  logic        ack_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;
  logic [7:0]  lut_a [3][256];
  logic [7:0]  lut_b [3][256];

  logic [11:0] idx;
  logic        req;
  logic        wr_go;
  logic        rd_go;
  logic        low_en;
  logic        hit_ctl;
  logic        hit_adr;
  logic        hit_dat;
  logic        hit_psc;
  logic        host_a;
  logic        host_b;
  logic        lut_wr;
  logic [1:0]  bank;
  logic [1:0]  wcol;
  logic [7:0]  wbyte;

  assign idx     = 12'(avs_address >> 2);
  assign req     = (avs_read || avs_write) && !ack_q;
  assign wr_go   = avs_write && req;
  assign rd_go   = avs_read && req;
  assign low_en  = avs_byteenable[0];
  assign hit_ctl = (idx == GMLUT_IDX_CONTROL) && (avs_address[1:0] == 2'h0);
  assign hit_adr = (idx == GMLUT_IDX_ADDRESS) && (avs_address[1:0] == 2'h0);
  assign hit_dat = (idx == GMLUT_IDX_DATA) && (avs_address[1:0] == 2'h0);
  assign hit_psc = (idx == GMLUT_IDX_PSEUDO) && (avs_address[1:0] == 2'h0);
  assign bank    = ctl_q[GMLUT_CTL_BANK_LO +: 2];
  assign wcol    = ctl_q[GMLUT_CTL_WCOL_LO +: 2];
  assign wbyte   = avs_writedata[7:0];

  // Host may only touch a bank that is not serving the display.
  assign host_a = ctl_q[GMLUT_CTL_ENABLE] &&
                  (bank == GMLUT_BANK_B_SHOW || bank == GMLUT_BANK_BOTH_WR);
  assign host_b = ctl_q[GMLUT_CTL_ENABLE] &&
                  (bank == GMLUT_BANK_A_SHOW || bank == GMLUT_BANK_BOTH_WR);
  assign lut_wr = wr_go && hit_dat && low_en;

  // Waitrequest has its own flop so that the pin comes straight from a register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !req;
    end
  end

  // Each access is answered one cycle after it is seen.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
    end else begin
      ack_q <= req;
      if (rd_go) begin
        resp_q  <= 2'h0;
        rdata_q <= 32'h0000_0000;
        if (hit_ctl) begin
          rdata_q <= {16'h0000, ctl_q};
        end else if (hit_psc) begin
          rdata_q <= {16'h0000, psc_q};
        end else if (hit_dat) begin
          // Reads return the red component of the host-side bank, or zero when bank select is 11.
          if (host_b && bank != GMLUT_BANK_BOTH_WR) begin
            rdata_q <= {24'h000000, lut_b[0][addr_q]};
          end else if (host_a && bank != GMLUT_BANK_BOTH_WR) begin
            rdata_q <= {24'h000000, lut_a[0][addr_q]};
          end
        end else if (!hit_adr) begin
          resp_q <= 2'h2;
        end
      end else if (wr_go) begin
        resp_q <= (hit_ctl || hit_adr || hit_dat || hit_psc) ? 2'h0 : 2'h2;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= GMLUT_CTL_RESET;
      psc_q <= GMLUT_PSC_RESET;
    end else if (wr_go && low_en) begin
      if (hit_ctl) begin
        ctl_q[7:0] <= wbyte & GMLUT_CTL_MASK[7:0];
      end
      if (hit_psc) begin
        psc_q <= {8'h00, wbyte} & GMLUT_PSC_MASK;
      end
      if (hit_ctl && avs_byteenable[1]) begin
        ctl_q[15:8] <= avs_writedata[15:8] & GMLUT_CTL_MASK[15:8];
      end
    end else if (wr_go && hit_ctl && avs_byteenable[1]) begin
      ctl_q[15:8] <= avs_writedata[15:8] & GMLUT_CTL_MASK[15:8];
    end
  end

  // A data write that no bank accepts leaves the access address where it was.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= GMLUT_ADDR_RESET;
    end else if (wr_go && hit_adr && low_en) begin
      addr_q <= wbyte;
    end else if (lut_wr && (host_a || host_b) && ctl_q[GMLUT_CTL_AUTOINC]) begin
      addr_q <= addr_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Table storage
  // ---------------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_comp
      logic sel;
      assign sel = (wcol == GMLUT_WCOL_ALL) || (wcol == 2'(c));
      always_ff @(posedge clk) begin
        if (lut_wr && sel && host_a) begin
          lut_a[c][addr_q] <= wbyte;
        end
        if (lut_wr && sel && host_b) begin
          lut_b[c][addr_q] <= wbyte;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Gamma input conditioning
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] gmlut_cond(input logic [7:0] v, input logic [7:0] xm,
                                             input logic clip_dis, input logic expand);
    logic [7:0] r;
    r = v;
    if (!clip_dis) begin
      if (expand) begin
        r = (v & ~xm) | ({8{v[7]}} & xm);
      end else begin
        r = v & ~xm;
      end
    end
    return r;
  endfunction

  // Decides which bank, if any, corrects a pixel of a given window.
  function automatic logic [1:0] gmlut_route(input logic [15:0] ctl, input logic [1:0] win);
    logic [1:0] bsel;
    logic [1:0] ovl;
    logic       byp;
    bsel = ctl[GMLUT_CTL_BANK_LO +: 2];
    ovl  = ctl[GMLUT_CTL_OVL_LO +: 2];
    byp  = (win == GMLUT_WIN_MAIN) ? ctl[GMLUT_CTL_BYP_MAIN] :
           (win == GMLUT_WIN_OV1) ? ctl[GMLUT_CTL_BYP_OV1] : ctl[GMLUT_CTL_BYP_OV2];
    if (!ctl[GMLUT_CTL_ENABLE] || byp) begin
      return 2'h0;
    end
    case (bsel)
      GMLUT_BANK_A_SHOW: return (win == GMLUT_WIN_OV2) ? 2'h0 : 2'h1;
      GMLUT_BANK_B_SHOW: return (win == GMLUT_WIN_OV2) ? 2'h0 : 2'h2;
      GMLUT_BANK_SPLIT: begin
        if (win == GMLUT_WIN_MAIN) begin
          return 2'h1;
        end
        case (ovl)
          GMLUT_OVL_BOTH: return 2'h2;
          GMLUT_OVL_ONE:  return (win == GMLUT_WIN_OV1) ? 2'h2 : 2'h0;
          GMLUT_OVL_TWO:  return (win == GMLUT_WIN_OV2) ? 2'h2 : 2'h0;
          default:        return 2'h0;
        endcase
      end
      default: return 2'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Pixel pipeline
  // ---------------------------------------------------------------------------
  logic       s1_valid_q;
  logic [1:0] s1_route_q;
  logic [7:0] s1_pix_q [3];
  logic       s2_valid_q;
  logic [7:0] s2_pix_q [3];
  logic [7:0] cin [3];
  logic [7:0] xin [3];

  assign cin[0] = pix_in.red;
  assign cin[1] = pix_in.green;
  assign cin[2] = pix_in.blue;
  assign xin[0] = pix_in.red_xmask;
  assign xin[1] = pix_in.green_xmask;
  assign xin[2] = pix_in.blue_xmask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_valid_q <= 1'b0;
      s1_route_q <= 2'h0;
      s2_valid_q <= 1'b0;
    end else begin
      s1_valid_q <= pix_in.valid;
      s1_route_q <= gmlut_route(ctl_q, pix_in.window);
      s2_valid_q <= s1_valid_q;
    end
  end

  // Stage one conditions the input; stage two looks up the routed bank.
  generate
    for (c = 0; c < 3; c++) begin : g_pipe
      always_ff @(posedge clk) begin
        s1_pix_q[c] <= gmlut_cond(cin[c], xin[c], ctl_q[GMLUT_CTL_CLIP_DIS],
                                  ctl_q[GMLUT_CTL_EXPAND]);
        case (s1_route_q)
          2'h1:    s2_pix_q[c] <= lut_a[c][s1_pix_q[c]];
          2'h2:    s2_pix_q[c] <= lut_b[c][s1_pix_q[c]];
          default: s2_pix_q[c] <= s1_pix_q[c];
        endcase
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Pseudo colour reduction to the panel width
  // ---------------------------------------------------------------------------
  logic       phase_x_q;
  logic       phase_y_q;
  logic [1:0] frame_q;
  logic [1:0] err_q [3];
  logic [5:0] red_o;
  logic [5:0] grn_o;
  logic [5:0] blu_o;
  logic [5:0] outc [3];
  logic [1:0] thr;

  // Threshold for the two dropped bits: 2x2 ordered matrix, or frame phase.
  always_comb begin
    case (psc_q[2:0])
      GMLUT_PSC_DITHER: thr = {phase_y_q ^ phase_x_q, phase_y_q};
      GMLUT_PSC_FRM:    thr = frame_q;
      default:          thr = 2'h0;
    endcase
  end

  generate
    for (c = 0; c < 3; c++) begin : g_red
      logic [2:0] sum;
      logic [5:0] hi;
      logic       up;
      assign hi  = s2_pix_q[c][7:2];
      assign sum = {1'b0, s2_pix_q[c][1:0]} + {1'b0, err_q[c]};
      always_comb begin
        case (psc_q[2:0])
          GMLUT_PSC_DITHER, GMLUT_PSC_FRM: up = (s2_pix_q[c][1:0] > thr);
          GMLUT_PSC_ERRDIF:                up = sum[2];
          default:                         up = 1'b0;
        endcase
        outc[c] = (up && hi != 6'h3f) ? hi + 6'h01 : hi;
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          err_q[c] <= 2'h0;
        end else if (frame_start) begin
          err_q[c] <= 2'h0;
        end else if (s2_valid_q && psc_q[2:0] == GMLUT_PSC_ERRDIF) begin
          err_q[c] <= sum[1:0];
        end
      end
    end
  endgenerate

  assign red_o = outc[0];
  assign grn_o = outc[1];
  assign blu_o = outc[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_x_q <= 1'b0;
      phase_y_q <= 1'b0;
      frame_q   <= 2'h0;
    end else if (frame_start) begin
      phase_x_q <= 1'b0;
      // No line marker reaches this block, so the matrix row alternates per frame.
      phase_y_q <= ~phase_y_q;
      frame_q   <= frame_q + 2'h1;
    end else if (s2_valid_q) begin
      phase_x_q <= ~phase_x_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_out <= '0;
    end else begin
      pix_out.valid <= s2_valid_q;
      pix_out.red   <= red_o;
      pix_out.green <= grn_o;
      pix_out.blue  <= blu_o;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign avs_response    = resp_q;

endmodule

// ==== tb/gmlut_assertions.sv ====
`timescale 1ns/1ns
module gmlut_assertions
  import gmlut_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire logic [GMLUT_BUS_AW-1:0] avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  input wire logic [1:0]              avs_response,
  input wire gmlut_pix_in_t           pix_in,
  input wire logic                    frame_start,
  input wire gmlut_pix_out_t          pix_out
);
  // ---------------------------------------------------------------------------
  // Shadow of the control register
  // ---------------------------------------------------------------------------
  logic [13:0] a_ctl;
  logic [13:0] a_dat;
  logic        done;
  logic        mapped;
  logic [15:0] ctl_q;
  assign a_ctl  = {GMLUT_IDX_CONTROL, 2'h0};
  assign a_dat  = {GMLUT_IDX_DATA, 2'h0};
  assign done   = (avs_read || avs_write) && !avs_waitrequest;
  assign mapped = avs_address inside {a_ctl, a_dat, {GMLUT_IDX_ADDRESS, 2'h0},
                                      {GMLUT_IDX_PSEUDO, 2'h0}};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= GMLUT_CTL_RESET;
    end else if (done && avs_write && avs_address == a_ctl) begin
      ctl_q <= avs_writedata[15:0] & GMLUT_CTL_MASK;
    end
  end
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_wait_one_cycle: assert property (
    $rose(avs_read || avs_write) |=> !avs_waitrequest) else $error("late answer");
  a_ack_single: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer held");
  a_unmapped_err: assert property (
    done && !mapped |-> avs_response == 2'h2) else $error("no error");
  a_mapped_ok: assert property (
    done && mapped |-> avs_response == 2'h0) else $error("bad response");
  a_addr_wo: assert property (
    done && avs_read && avs_address == {GMLUT_IDX_ADDRESS, 2'h0} |-> avs_readdata == 32'h0)
    else $error("address readable");
  a_ctl_fields: assert property (
    done && avs_read && avs_address == a_ctl |-> avs_readdata[15:0] == ctl_q)
    else $error("control mismatch");
  a_tbl_locked: assert property (
    done && avs_read && avs_address == a_dat && (!ctl_q[0] || ctl_q[5])
    |-> avs_readdata == 32'h0) else $error("locked table read");
  a_pix_latency: assert property (
    pix_in.valid |-> ##3 pix_out.valid) else $error("pixel lost");
  a_pix_idle: assert property (
    !pix_in.valid |-> ##3 !pix_out.valid) else $error("spurious pixel");
  c_unmapped: cover property (done && !mapped);
  c_split_pix: cover property (pix_in.valid && ctl_q[5:4] == GMLUT_BANK_SPLIT);
  c_tbl_read: cover property (done && avs_read && avs_address == a_dat);
endmodule

bind gmlut_top gmlut_assertions u_chk (.clk, .arst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
  .pix_in, .frame_start, .pix_out);

// ==== tb/gmlut_host_model.sv ====
`timescale 1ns/1ns
module gmlut_host_model
  import gmlut_pkg::*;
(
  input  wire logic                    clk,
  output logic      [GMLUT_BUS_AW-1:0] avs_address,
  output logic                         avs_read,
  output logic                         avs_write,
  output logic      [31:0]             avs_writedata,
  output logic      [3:0]              avs_byteenable,
  input  wire logic [31:0]             avs_readdata,
  input  wire logic                    avs_waitrequest,
  input  wire logic [1:0]              avs_response
);
  initial begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'h3;
  end

  // Released write data is inverted so a stale value is never mistaken for live.
  task automatic access(input logic wr, input logic [11:0] idx, input logic [15:0] wd,
                        output logic [15:0] rd, output logic [1:0] rsp);
    @(posedge clk);
    avs_address   <= {idx, 2'h0};
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= {16'h0, wd};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd  = avs_readdata[15:0];
    rsp = avs_response;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_writedata <= ~avs_writedata;
  endtask
endmodule

// ==== tb/test_gamma_lut_color_pipeline.sv ====
`timescale 1ns/1ns
module test_gamma_lut_color_pipeline;
  import gmlut_pkg::*;
  logic                    clk;
  logic                    arst_n;
  logic [GMLUT_BUS_AW-1:0] avs_address;
  logic                    avs_read;
  logic                    avs_write;
  logic [31:0]             avs_writedata;
  logic [3:0]              avs_byteenable;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic [1:0]              avs_response;
  gmlut_pix_in_t           pix_in;
  logic                    frame_start;
  gmlut_pix_out_t          pix_out;
  int                      err_total;
  int                      checks_done;
  logic [15:0]             rd;
  logic [1:0]              rsp;

  gmlut_top DUT (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .pix_in,
    .frame_start, .pix_out);
  gmlut_host_model u_host (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pix(input logic [18:0] got, input logic [18:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [15:0] d);
    u_host.access(1'b1, idx, d, rd, rsp);
  endtask

  task automatic rdreg(input logic [11:0] idx, input logic [15:0] e);
    u_host.access(1'b0, idx, 16'h0, rd, rsp);
    cmp_reg(rd, e);
  endtask

  // The address is reloaded before every table read.
  task automatic tbl(input logic [7:0] a, input logic [7:0] e);
    wr(GMLUT_IDX_ADDRESS, {8'h0, a});
    rdreg(GMLUT_IDX_DATA, {8'h0, e});
  endtask

  task automatic setc(input logic [1:0] b, w, o, input logic [2:0] y, input logic ai, en);
    wr(GMLUT_IDX_CONTROL, {1'b0, y, o, w, 2'h0, b, 2'h0, ai, en});
  endtask

  task automatic pix(input logic [1:0] win, input logic [7:0] v, m, input logic [5:0] e);
    @(posedge clk);
    pix_in <= '{1'b1, win, v, v, v, m, m, m};
    @(posedge clk);
    pix_in.valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp_pix(pix_out, {1'b1, e, e, e});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end

  initial begin
    arst_n      = 1'b0;
    pix_in      = '0;
    frame_start = 1'b0;
    err_total   = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdreg(GMLUT_IDX_CONTROL, GMLUT_CTL_RESET);
    rdreg(GMLUT_IDX_PSEUDO, GMLUT_PSC_RESET);
    rdreg(GMLUT_IDX_ADDRESS, 16'h0000);
    wr(GMLUT_IDX_CONTROL, 16'hffff);
    rdreg(GMLUT_IDX_CONTROL, GMLUT_CTL_MASK);
    u_host.access(1'b0, 12'h846, 16'h0, rd, rsp);
    cmp_reg({14'h0, rsp}, 16'h0002);
    for (int i = 0; i < 5; i++) begin
      if (i != 3) begin
        wr(GMLUT_IDX_PSEUDO, 16'(i));
        rdreg(GMLUT_IDX_PSEUDO, 16'(i));
      end
    end
    wr(GMLUT_IDX_PSEUDO, 16'h0);
    $display("register test done");
    // Both banks, all colours, auto increment across the top entry.
    setc(2'h3, 2'h3, 2'h0, 3'h0, 1'b1, 1'b1);
    wr(GMLUT_IDX_ADDRESS, 16'h00ff);
    wr(GMLUT_IDX_DATA, 16'h005a);
    wr(GMLUT_IDX_DATA, 16'h0033);
    wr(GMLUT_IDX_DATA, 16'h000c);
    setc(2'h0, 2'h3, 2'h0, 3'h0, 1'b0, 1'b1);
    tbl(8'hff, 8'h5a);
    tbl(8'h01, 8'h0c);
    wr(GMLUT_IDX_DATA, 16'h0066);
    wr(GMLUT_IDX_DATA, 16'h0077);
    tbl(8'h01, 8'h77);
    tbl(8'h00, 8'h33);
    setc(2'h1, 2'h1, 2'h0, 3'h0, 1'b0, 1'b1);
    tbl(8'h01, 8'h0c);
    wr(GMLUT_IDX_DATA, 16'h0099);
    tbl(8'h01, 8'h0c);
    setc(2'h1, 2'h0, 2'h0, 3'h0, 1'b0, 1'b1);
    wr(GMLUT_IDX_DATA, 16'h0044);
    tbl(8'h01, 8'h44);
    setc(2'h2, 2'h3, 2'h0, 3'h0, 1'b0, 1'b1);
    wr(GMLUT_IDX_DATA, 16'h0011);
    tbl(8'h01, 8'h00);
    setc(2'h1, 2'h3, 2'h0, 3'h0, 1'b0, 1'b0);
    wr(GMLUT_IDX_DATA, 16'h0022);
    tbl(8'h01, 8'h00);
    setc(2'h1, 2'h3, 2'h0, 3'h0, 1'b0, 1'b1);
    tbl(8'h01, 8'h44);
    setc(2'h0, 2'h3, 2'h0, 3'h0, 1'b0, 1'b1);
    tbl(8'h01, 8'h77);
    $display("table access test done");
    // Entry 0x87 holds 0x44 in bank A and 0x80 in bank B before any display use.
    wr(GMLUT_IDX_ADDRESS, 16'h0087);
    wr(GMLUT_IDX_DATA, 16'h0080);
    setc(2'h1, 2'h3, 2'h0, 3'h0, 1'b0, 1'b1);
    wr(GMLUT_IDX_DATA, 16'h0044);
    pix(GMLUT_WIN_MAIN, 8'h87, 8'h0, 6'h20);
    setc(2'h0, 2'h3, 2'h2, 3'h0, 1'b0, 1'b1);
    pix(GMLUT_WIN_MAIN, 8'h87, 8'h0, 6'h11);
    pix(GMLUT_WIN_OV1, 8'h87, 8'h0, 6'h11);
    setc(2'h2, 2'h3, 2'h1, 3'h0, 1'b0, 1'b1);
    pix(GMLUT_WIN_MAIN, 8'h87, 8'h0, 6'h11);
    pix(GMLUT_WIN_OV1, 8'h87, 8'h0, 6'h20);
    pix(GMLUT_WIN_OV2, 8'h87, 8'h0, 6'h21);
    setc(2'h2, 2'h3, 2'h2, 3'h0, 1'b0, 1'b1);
    pix(GMLUT_WIN_OV1, 8'h87, 8'h0, 6'h21);
    pix(GMLUT_WIN_OV2, 8'h87, 8'h0, 6'h20);
    setc(2'h2, 2'h3, 2'h0, 3'h1, 1'b0, 1'b1);
    pix(GMLUT_WIN_OV1, 8'h87, 8'h0, 6'h21);
    pix(GMLUT_WIN_OV2, 8'h87, 8'h0, 6'h20);
    setc(2'h2, 2'h3, 2'h0, 3'h4, 1'b0, 1'b1);
    pix(GMLUT_WIN_MAIN, 8'h87, 8'h0, 6'h21);
    setc(2'h3, 2'h3, 2'h0, 3'h0, 1'b0, 1'b1);
    pix(GMLUT_WIN_MAIN, 8'h87, 8'h0, 6'h21);
    setc(2'h0, 2'h3, 2'h0, 3'h0, 1'b0, 1'b0);
    pix(GMLUT_WIN_MAIN, 8'h87, 8'h0, 6'h21);
    pix(GMLUT_WIN_MAIN, 8'h87, 8'h04, 6'h20);
    wr(GMLUT_IDX_CONTROL, 16'h0008);
    pix(GMLUT_WIN_MAIN, 8'h87, 8'h04, 6'h21);
    pix(GMLUT_WIN_MAIN, 8'h47, 8'h04, 6'h10);
    wr(GMLUT_IDX_CONTROL, 16'h0004);
    pix(GMLUT_WIN_MAIN, 8'h47, 8'h04, 6'h11);
    $display("pixel test done");
    // Table off, clip off: only the panel reduction acts on the low two bits.
    wr(GMLUT_IDX_PSEUDO, {13'h0, GMLUT_PSC_FRM});
    pix(GMLUT_WIN_MAIN, 8'h45, 8'h0, 6'h12);
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    pix(GMLUT_WIN_MAIN, 8'h45, 8'h0, 6'h11);
    wr(GMLUT_IDX_PSEUDO, {13'h0, GMLUT_PSC_DITHER});
    pix(GMLUT_WIN_MAIN, 8'h46, 8'h0, 6'h12);
    pix(GMLUT_WIN_MAIN, 8'h46, 8'h0, 6'h11);
    wr(GMLUT_IDX_PSEUDO, {13'h0, GMLUT_PSC_ERRDIF});
    pix(GMLUT_WIN_MAIN, 8'h46, 8'h0, 6'h11);
    pix(GMLUT_WIN_MAIN, 8'h46, 8'h0, 6'h12);
    $display("pseudo colour test done");
    stop_test();
  end
endmodule
